// *** otp_memory_controller.sv ***
// one-time-programmable memory controller: slave window, dma master,
// word fifo, macro timing sequencer and power manager mirror handshake
// assumes the macro, both buses and the power manager share clk
`timescale 1ns/100ps
`include "otp_memory_controller_map.svh"

module otp_memory_controller
  import otp_pkg::*;
#(
  parameter int AW    = 13,
  parameter int WCW   = 13,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // control and status
  input  wire op_mode_type      operating_mode_field,
  input  wire logic             prog_start,
  input  wire logic [AW+4:0]    prog_bit_addr,
  input  wire logic             prog_bit_value,
  input  wire logic [1:0]       bank_prog_en,
  input  wire logic             dma_start,
  input  wire logic             dma_from_slave,
  input  wire logic [31:0]      dma_start_address_field,
  input  wire logic [WCW-1:0]   dma_word_count_field,
  input  wire logic [AW-1:0]    otp_start_word,
  output logic [1:0]            prog_pass,
  output logic                  busy,
  output logic                  xfer_done,
  // power manager
  input  wire logic             dev_mode,
  input  wire logic             pmu_mirror_req,
  output logic                  pmu_mirror_ack,
  // slave window
  input  wire logic             s_hsel,
  input  wire logic [15:0]      s_haddr,
  input  wire logic [1:0]       s_htrans,
  input  wire logic             s_hwrite,
  input  wire logic             s_hready,
  input  wire logic [31:0]      s_hwdata,
  output logic                  s_hreadyout,
  output logic [31:0]           s_hrdata,
  // dma master
  input  wire logic             m_hready,
  input  wire logic [31:0]      m_hrdata,
  output logic [31:0]           m_haddr,
  output logic [1:0]            m_htrans,
  output logic [2:0]            m_hburst,
  output logic                  m_hwrite,
  output logic [31:0]           m_hwdata,
  // memory macro, two banks read side by side
  input  wire logic [63:0]      macro_rdata,
  output logic [AW-1:0]         macro_addr,
  output logic                  macro_ce,
  output logic                  macro_prog,
  output logic [31:0]           macro_wdata,
  output logic [1:0]            macro_bank_sel,
  output logic                  macro_standby
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [11:0] ACC_LAST  = 12'(`ACC_CYC - 1);
  localparam logic [11:0] PROG_LAST = 12'(`PROG_CYC - 1);
  localparam logic [PW:0] FULL_CNT  = (PW+1)'(DEPTH);

  typedef struct packed {
    ctl_state_type  state;
    logic [11:0]    tmr;
    logic           run;
    logic           auto_prog;
    logic           src_slave;
    logic           mirror;
    logic           pmu_req_q;
    logic [WCW:0]   otp_left;
    logic [WCW:0]   mst_left;
    logic [AW-1:0]  wl_addr;
    logic [4:0]     bit_idx;
    logic           bit_val;
    logic           s_pend_rd;
    logic           s_pend_wr;
    logic [AW-1:0]  s_addr;
    logic [2:0]     beats;
    logic           dph_valid;
    logic [PW-1:0]  wr_ptr;
    logic [PW-1:0]  rd_ptr;
    logic [PW:0]    cnt;
    logic [1:0]     prog_pass;
    logic           xfer_done;
    logic           pmu_ack;
    logic           s_hreadyout;
    logic [31:0]    s_hrdata;
    logic [31:0]    m_haddr;
    logic [1:0]     m_htrans;
    logic [2:0]     m_hburst;
    logic           m_hwrite;
    logic [31:0]    m_hwdata;
    logic [AW-1:0]  macro_addr;
    logic           macro_ce;
    logic           macro_prog;
    logic [31:0]    macro_wdata;
    logic [1:0]     macro_bank_sel;
    logic           macro_standby;
  } ctl_type;

  localparam ctl_type CTL_RESET = '{state: st_idle, s_hreadyout: 1'b1,
    macro_standby: 1'b1, default: '0};

  logic        rst_q1;
  logic        rst_n;
  ctl_type     r;
  ctl_type     n;
  logic [31:0] fifo_mem [DEPTH];
  logic        push;
  logic        pop;
  logic [31:0] push_data;
  logic        start_sw;
  logic        start_hw;
  logic [2:0]  len;
  logic [31:0] rd_word;
  logic [1:0]  ok;
  wire         fifo_full  = r.cnt == FULL_CNT;
  wire         fifo_empty = r.cnt == '0;
  wire [31:0]  fifo_head  = fifo_mem[r.rd_ptr];

  // reset release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_comb
  begin
    n = r;
    push = 1'b0;
    pop = 1'b0;
    push_data = '0;
    ok = 2'b00;
    rd_word = macro_rdata[31:0] | macro_rdata[63:32];
    len = (r.mst_left >= (WCW+1)'(4)) ? 3'd4 : r.mst_left[2:0];
    n.xfer_done = 1'b0;
    n.pmu_req_q = pmu_mirror_req;
    if (!pmu_mirror_req)
      n.pmu_ack = 1'b0;
    // job start from software or from the power manager
    start_sw = dma_start && !r.run && r.state == st_idle &&
      (operating_mode_field == auto_read_mode ||
       operating_mode_field == auto_program_mode);
    start_hw = pmu_mirror_req && !r.pmu_req_q && !dev_mode &&
      !r.run && r.state == st_idle;
    if (start_sw || start_hw)
    begin
      n.run = 1'b1;
      n.mirror = start_hw;
      n.auto_prog = !start_hw &&
        operating_mode_field == auto_program_mode;
      n.src_slave = n.auto_prog && dma_from_slave;
      n.otp_left = (WCW+1)'(dma_word_count_field) + 1'b1;
      n.mst_left = n.src_slave ? '0 : n.otp_left;
      n.wl_addr = otp_start_word;
      n.m_haddr = dma_start_address_field;
      if (n.auto_prog)
        n.prog_pass = 2'b11;
    end
    // slave window
    if (s_hsel && s_hready && s_htrans[1] && r.s_hreadyout)
    begin
      if (!s_hwrite && operating_mode_field == manual_read_mode)
      begin
        n.s_pend_rd = 1'b1;
        n.s_hreadyout = 1'b0;
        n.s_addr = s_haddr[AW+1:2];
      end
      else if (s_hwrite && s_haddr == `FIFO_PORT_OFS && r.src_slave &&
        r.run && r.otp_left != '0)
      begin
        n.s_pend_wr = 1'b1;
        n.s_hreadyout = 1'b0;
      end
      else if (!s_hwrite)
        n.s_hrdata = '0;
    end
    if (r.s_pend_wr && !fifo_full)
    begin
      push = 1'b1;
      push_data = s_hwdata;
      n.s_pend_wr = 1'b0;
      n.s_hreadyout = 1'b1;
    end
    // dma master, address and data phases pipelined
    if (r.dph_valid && m_hready)
    begin
      n.dph_valid = 1'b0;
      if (!r.m_hwrite)
      begin
        push = 1'b1;
        push_data = m_hrdata;
      end
    end
    if (r.m_htrans[1] && m_hready)
    begin
      n.dph_valid = 1'b1;
      n.m_haddr = r.m_haddr + 32'h4;
      n.beats = r.beats - 3'd1;
      n.mst_left = r.mst_left - 1'b1;
      n.m_htrans = (r.beats > 3'd1) ? `HTRANS_SEQ : `HTRANS_IDLE;
      if (r.m_hwrite)
      begin
        pop = 1'b1;
        n.m_hwdata = fifo_head;
      end
    end
    else if (r.run && !r.src_slave && r.m_htrans == `HTRANS_IDLE &&
      !r.dph_valid && r.mst_left != '0 &&
      (r.auto_prog ? (FULL_CNT - r.cnt) >= (PW+1)'(len)
                   : r.cnt >= (PW+1)'(len)))
    begin
      n.m_htrans = `HTRANS_NONSEQ;
      n.m_hburst = (len == 3'd4) ? `HBURST_INCR4 :
        (len == 3'd1) ? `HBURST_SINGLE : `HBURST_INCR;
      n.m_hwrite = !r.auto_prog;
      n.beats = len;
    end
    // macro sequencer
    unique case (r.state)
      st_idle:
      begin
        n.macro_standby = 1'b0;
        if (r.s_pend_rd)
        begin
          n.state = st_read;
          n.macro_addr = r.s_addr;
        end
        else if (r.run && !r.auto_prog && r.otp_left != '0 && !fifo_full)
        begin
          n.state = st_read;
          n.macro_addr = r.wl_addr;
        end
        else if (r.run && r.auto_prog && r.otp_left != '0 && !fifo_empty)
        begin
          pop = 1'b1;
          n.state = st_prog;
          n.macro_addr = r.wl_addr;
          n.macro_wdata = fifo_head;
          n.macro_bank_sel = bank_prog_en;
        end
        else if (!r.run && prog_start && bank_prog_en != 2'b00 &&
          operating_mode_field == manual_program_mode)
        begin
          n.state = st_prog;
          n.macro_addr = prog_bit_addr[AW+4:5];
          n.bit_idx = prog_bit_addr[4:0];
          n.bit_val = prog_bit_value;
          n.macro_wdata = {31'h0, prog_bit_value} << prog_bit_addr[4:0];
          n.macro_bank_sel = bank_prog_en;
        end
        else if (r.run && r.otp_left == '0 && r.mst_left == '0 &&
          !r.dph_valid && !r.s_pend_wr && fifo_empty)
          n.state = st_done;
        else
          n.macro_standby = 1'b1;
        n.tmr = (n.state == st_prog) ? PROG_LAST : ACC_LAST;
        n.macro_ce = n.state == st_read;
        n.macro_prog = n.state == st_prog;
      end
      st_read:
      begin
        n.tmr = r.tmr - 12'd1;
        if (r.tmr == '0)
        begin
          n.state = st_idle;
          n.macro_ce = 1'b0;
          if (r.s_pend_rd)
          begin
            n.s_pend_rd = 1'b0;
            n.s_hreadyout = 1'b1;
            n.s_hrdata = rd_word;
          end
          else
          begin
            push = 1'b1;
            push_data = rd_word;
            n.otp_left = r.otp_left - 1'b1;
            n.wl_addr = r.wl_addr + 1'b1;
          end
        end
      end
      st_prog:
      begin
        n.tmr = r.tmr - 12'd1;
        if (r.tmr == '0)
        begin
          n.state = st_verify;
          n.macro_prog = 1'b0;
          n.macro_ce = 1'b1;
          n.tmr = ACC_LAST;
        end
      end
      st_verify:
      begin
        n.tmr = r.tmr - 12'd1;
        if (r.tmr == '0)
        begin
          n.state = st_idle;
          n.macro_ce = 1'b0;
          for (int b = 0; b < 2; b++)
          begin
            ok[b] = r.auto_prog ?
              macro_rdata[32*b +: 32] == r.macro_wdata :
              macro_rdata[32*b + int'(r.bit_idx)] == r.bit_val;
            if (r.macro_bank_sel[b])
              n.prog_pass[b] = r.run ? r.prog_pass[b] & ok[b]
                                     : ok[b];
          end
          if (r.run)
          begin
            n.otp_left = r.otp_left - 1'b1;
            n.wl_addr = r.wl_addr + 1'b1;
          end
        end
      end
      st_done:
      begin
        n.state = st_idle;
        n.run = 1'b0;
        n.mirror = 1'b0;
        n.xfer_done = 1'b1;
        n.macro_standby = 1'b1;
        n.pmu_ack = r.mirror || (dev_mode && pmu_mirror_req);
      end
    endcase
    if (push)
      n.wr_ptr = r.wr_ptr + 1'b1;
    if (pop)
      n.rd_ptr = r.rd_ptr + 1'b1;
    n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= CTL_RESET;
    else
      r <= n;
  end

  always_ff @(posedge clk)
  begin
    if (push)
      fifo_mem[r.wr_ptr] <= push_data;
  end

  assign prog_pass      = r.prog_pass;
  assign busy           = r.run;
  assign xfer_done      = r.xfer_done;
  assign pmu_mirror_ack = r.pmu_ack;
  assign s_hreadyout    = r.s_hreadyout;
  assign s_hrdata       = r.s_hrdata;
  assign m_haddr        = r.m_haddr;
  assign m_htrans       = r.m_htrans;
  assign m_hburst       = r.m_hburst;
  assign m_hwrite       = r.m_hwrite;
  assign m_hwdata       = r.m_hwdata;
  assign macro_addr     = r.macro_addr;
  assign macro_ce       = r.macro_ce;
  assign macro_prog     = r.macro_prog;
  assign macro_wdata    = r.macro_wdata;
  assign macro_bank_sel = r.macro_bank_sel;
  assign macro_standby  = r.macro_standby;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  man_step_a: assert property ($rose(macro_prog) && !busy |->
    $past(prog_start) && $past(operating_mode_field) == manual_program_mode)
    else $error("manual program step without request");
  bank_gate_a: assert property ($rose(macro_prog) |->
    macro_bank_sel == $past(bank_prog_en) && macro_bank_sel != 2'b00)
    else $error("program bank select not taken from enables");
  pass_keep_a: assert property (r.state == st_verify &&
    r.tmr == '0 && !r.macro_bank_sel[1] |=> $stable(prog_pass[1]))
    else $error("disabled bank status changed");
  slave_read_a: assert property (r.state == st_read &&
    r.tmr == '0 && r.s_pend_rd |=> s_hreadyout && s_hrdata == $past(rd_word))
    else $error("window read data wrong");
  acc_time_a: assert property ($rose(macro_ce) |->
    macro_ce [*8] ##1 !macro_ce)
    else $error("macro access time wrong");
  fifo_bound_a: assert property (r.cnt <= FULL_CNT)
    else $error("fifo overflow");
  burst_kind_a: assert property (m_htrans == `HTRANS_NONSEQ |->
    (m_hburst == `HBURST_INCR4) == (r.beats == 3'd4) &&
    (m_hburst == `HBURST_SINGLE) == (r.beats == 3'd1))
    else $error("illegal burst kind");
  start_addr_a: assert property (start_sw |=>
    m_haddr == $past(dma_start_address_field))
    else $error("dma start address not loaded");
  slave_stall_a: assert property (r.s_pend_wr && fifo_full |->
    !s_hreadyout ##1 (r.s_pend_wr || r.cnt != '0))
    else $error("slave write lost on full fifo");
  done_idle_a: assert property (xfer_done |-> !busy &&
    macro_standby && r.state == st_idle)
    else $error("completion without standby");
  mirror_ack_a: assert property ($rose(pmu_mirror_ack) |->
    $past(r.state == st_done))
    else $error("mirror ack before completion");

  incr4_c: cover property (m_htrans == `HTRANS_NONSEQ &&
    m_hburst == `HBURST_INCR4 && m_hready);
  man_prog_c: cover property (r.state == st_verify && !busy ##1
    r.state == st_idle);
  mirror_c: cover property ($rose(pmu_mirror_ack));
  stall_c: cover property (r.s_pend_wr && fifo_full);
endmodule

// *** otp_memory_controller_map.svh ***
// offsets, encodings and timing counts of the one-time-programmable
// memory controller; included by the controller module and its testbench
`ifndef OTP_MEMORY_CONTROLLER_MAP_SVH
`define OTP_MEMORY_CONTROLLER_MAP_SVH
`define CLK_MHZ        200
`define ACC_NS         40
`define ACC_CYC        ((`ACC_NS * `CLK_MHZ + 999) / 1000)
`define PROG_US        10
`define PROG_CYC       (`PROG_US * `CLK_MHZ)
`define FIFO_PORT_OFS  16'hfffc
`define HTRANS_IDLE    2'h0
`define HTRANS_NONSEQ  2'h2
`define HTRANS_SEQ     2'h3
`define HBURST_SINGLE  3'h0
`define HBURST_INCR    3'h1
`define HBURST_INCR4   3'h3
`endif

// *** otp_pkg.sv ***
// types shared by the memory controller and its testbench
// assumes nothing of its surroundings
package otp_pkg;
  typedef enum logic [2:0]
  {
    standby_mode,
    manual_read_mode,
    auto_read_mode,
    manual_program_mode,
    auto_program_mode
  } op_mode_type;
  typedef enum logic [2:0]
  {
    st_idle,
    st_read,
    st_prog,
    st_verify,
    st_done
  } ctl_state_type;
endpackage

// *** otp_bus_partner.sv ***
// far side model: system ram on the dma master port and the memory macro
// assumes the controller and this model share clk
`timescale 1ns/100ps
module otp_bus_partner
(
  // clock and knobs
  input  wire logic        clk,
  input  wire logic        stuck,
  input  wire logic        slow,
  // dma master port
  input  wire logic [31:0] m_haddr,
  input  wire logic [1:0]  m_htrans,
  input  wire logic        m_hwrite,
  input  wire logic [31:0] m_hwdata,
  output logic             m_hready,
  output logic [31:0]      m_hrdata,
  // memory macro
  input  wire logic [12:0] macro_addr,
  input  wire logic        macro_ce,
  input  wire logic        macro_prog,
  input  wire logic [31:0] macro_wdata,
  input  wire logic [1:0]  macro_bank_sel,
  output logic [63:0]      macro_rdata,
  output int               prog_cnt
);
  logic [31:0] ram [1024];
  logic [31:0] p0 [8192];
  logic [31:0] p1 [8192];
  logic [15:0] cnt = '0;
  logic        dv = 1'b0;
  logic        dw = 1'b0;
  logic        pq = 1'b0;
  logic [31:0] da = '0;
  logic [31:0] b0;
  logic [31:0] b1;
  initial prog_cnt = 0;
  initial foreach (p0[i]) {p0[i], p1[i]} = '0;
  assign b0 = {19'h0, macro_addr} | p0[macro_addr];
  assign b1 = {macro_addr, 19'h0} | p1[macro_addr];
  // unselected macro and idle bus show a moving pattern, not stale data
  assign macro_rdata = macro_ce ? {b1, b0} : {~cnt, cnt, ~cnt, cnt};
  assign m_hready = !(slow && cnt[1:0] == 2'h1);
  assign m_hrdata = (dv && !dw) ? ram[da[11:2]] : {cnt, ~cnt};
  always @(posedge clk)
  begin
    cnt <= cnt + 16'h1;
    pq <= macro_prog;
    if (macro_prog && !pq)
    begin
      prog_cnt <= prog_cnt + 1;
      if (!stuck && macro_bank_sel[0])
        p0[macro_addr] <= p0[macro_addr] | macro_wdata;
      if (!stuck && macro_bank_sel[1])
        p1[macro_addr] <= p1[macro_addr] | macro_wdata;
    end
    if (m_hready)
    begin
      if (dv && dw)
        ram[da[11:2]] <= m_hwdata;
      dv <= m_htrans[1];
      dw <= m_hwrite;
      da <= m_haddr;
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench of the memory controller
// assumes otp_bus_partner stands for ram and macro
`timescale 1ns/100ps
`include "otp_memory_controller_map.svh"
module testbench;
  import otp_pkg::*;
  logic clk = 0, arst_n = 0, prog_start = 0, prog_bit_value = 0;
  logic dma_start = 0, dma_from_slave = 0, dev_mode = 0, pmu_mirror_req = 0;
  logic s_hsel = 0, s_hwrite = 0, stuck = 0, slow = 0, rd_ph = 0;
  op_mode_type operating_mode_field = standby_mode;
  logic [17:0] prog_bit_addr = '0;
  logic [1:0]  bank_prog_en = '0, s_htrans = '0, prog_pass, m_htrans;
  logic [1:0]  macro_bank_sel;
  logic [31:0] dma_start_address_field = '0, s_hwdata = '0, s_hrdata;
  logic [31:0] m_hrdata, m_haddr, m_hwdata, macro_wdata;
  logic [12:0] dma_word_count_field = '0, otp_start_word = '0, macro_addr;
  logic [15:0] s_haddr = '0;
  logic        busy, xfer_done, pmu_mirror_ack, s_hreadyout, m_hready;
  logic        m_hwrite, macro_ce, macro_prog, macro_standby;
  logic [2:0]  m_hburst;
  logic [63:0] macro_rdata;
  logic [31:0] rq[$], aq[$], bq[$], w[12];
  int          failures = 0, samples_checked = 0, cyc = 0, waitn, n, prog_cnt;
  otp_memory_controller uut (.clk, .arst_n, .operating_mode_field,
    .prog_start, .prog_bit_addr, .prog_bit_value, .bank_prog_en, .dma_start,
    .dma_from_slave, .dma_start_address_field, .dma_word_count_field,
    .otp_start_word, .prog_pass, .busy, .xfer_done, .dev_mode,
    .pmu_mirror_req, .pmu_mirror_ack, .s_hsel, .s_haddr, .s_htrans,
    .s_hwrite, .s_hready(s_hreadyout), .s_hwdata, .s_hreadyout, .s_hrdata,
    .m_hready, .m_hrdata, .m_haddr, .m_htrans, .m_hburst, .m_hwrite,
    .m_hwdata, .macro_rdata, .macro_addr, .macro_ce, .macro_prog,
    .macro_wdata, .macro_bank_sel, .macro_standby);
  otp_bus_partner partner (.clk, .stuck, .slow, .m_haddr, .m_htrans,
    .m_hwrite, .m_hwdata, .m_hready, .m_hrdata, .macro_addr, .macro_ce,
    .macro_prog, .macro_wdata, .macro_bank_sel, .macro_rdata, .prog_cnt);
  // one clock feeds controller and macro model alike
  always #2.5 clk = ~clk;
  function automatic logic [31:0] pat(input logic [12:0] a);
    return {a, 19'h0} | {19'h0, a};
  endfunction
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // result watcher: slave read data and master beats against notes
  always @(posedge clk)
  begin
    if (rd_ph && s_hreadyout === 1'b1) check(rq.pop_front(), s_hrdata);
    if (m_htrans[1] && m_hready)
    begin
      check(aq.pop_front(), m_haddr);
      if (m_htrans == `HTRANS_NONSEQ)
        check(bq.pop_front(), {29'h0, m_hburst});
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      finish_test;
    end
  end
  task automatic ahb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    s_hsel = 1;
    s_htrans = `HTRANS_NONSEQ;
    s_hwrite = wr;
    s_haddr = a;
    @(posedge clk);
    while (s_hreadyout !== 1'b1) @(posedge clk);
    #1 s_hsel = 0;
    s_htrans = `HTRANS_IDLE;
    s_hwdata = d;
    rd_ph = !wr;
    waitn = 0;
    @(posedge clk);
    while (s_hreadyout !== 1'b1 && waitn < 9000)
    begin
      waitn++;
      @(posedge clk);
    end
    #1 rd_ph = 0;
    if (waitn == 9000)
      failures++;
  endtask
  task automatic job(input op_mode_type m, input logic [31:0] ad,
                     input logic [12:0] nw, input logic [12:0] ow,
                     input logic power_management_unit);
    operating_mode_field = m;
    dma_start_address_field = ad;
    dma_word_count_field = nw;
    otp_start_word = ow;
    for (int i = 0; i <= nw; i++) aq.push_back(ad + 4 * i);
    for (int r = nw + 1; r > 0; r -= 4)
      bq.push_back(r > 3 ? `HBURST_INCR4 : r > 1 ? `HBURST_INCR
                                                  : `HBURST_SINGLE);
    if (power_management_unit) pmu_mirror_req = 1;
    else dma_start = 1;
    @(posedge clk);
    #1 dma_start = 0;
  endtask
  task automatic wait_done;
    n = 0;
    while (xfer_done !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(3, {busy, xfer_done, macro_standby});
    check(0, aq.size() + bq.size());
  endtask
  task automatic step(input logic [17:0] a, input logic [1:0] en,
                      input logic stk, input logic exp_prog);
    prog_bit_addr = a;
    prog_bit_value = 1;
    bank_prog_en = en;
    stuck = stk;
    prog_start = 1;
    @(posedge clk);
    #1 prog_start = 0;
    @(posedge clk);
    #1 check(exp_prog, macro_prog);
    // a manual step never raises busy; wait out program and verify
    n = 0;
    while ((macro_prog || macro_ce) !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 5000)
      failures++;
  endtask
  initial
  begin
    void'($urandom(32'hd609));
    repeat (6) @(posedge clk);
    #1 arst_n = 1;
    repeat (4) @(posedge clk);
    #1 operating_mode_field = manual_program_mode;
    step({13'd5, 5'd20}, 2'b11, 0, 1);
    check(3, prog_pass);
    step({13'd6, 5'd21}, 2'b01, 1, 1);
    check(2, prog_pass);
    step({13'd7, 5'd1}, 2'b00, 0, 0);
    repeat (100) @(posedge clk);
    #1 check(2, prog_cnt);
    for (int m = 0; m < 2; m++)
    begin
      operating_mode_field = m ? manual_read_mode : standby_mode;
      rq.push_back(m ? pat(13'd5) | 32'h0010_0000 : 32'h0);
      ahb(0, 16'd20, 0);
    end
    slow = 1;
    job(auto_read_mode, 32'h2000_0100, 5, 40, 0);
    wait_done;
    for (int i = 0; i < 6; i++)
      check(pat(40 + i), partner.ram[10'h040 + i]);
    for (int d = 0; d < 2; d++)
    begin
      dev_mode = d;
      job(auto_read_mode, 32'h2000_0200, 2, 60 + 10 * d, 1);
      if (d)
      begin
        repeat (3) @(posedge clk);
        #1 check(0, busy);
        dma_start = 1;
        @(posedge clk);
        #1 dma_start = 0;
      end
      wait_done;
      @(posedge clk);
      #1 check(1, pmu_mirror_ack);
      pmu_mirror_req = 0;
      repeat (2) @(posedge clk);
      #1 check(0, pmu_mirror_ack);
      check(pat(62 + 10 * d), partner.ram[10'h082]);
    end
    slow = 0;
    bank_prog_en = 2'b11;
    for (int i = 0; i < 2; i++)
    begin
      w[i] = $urandom | pat(100 + i);
      partner.ram[10'h0c0 + i] = w[i];
    end
    job(auto_program_mode, 32'h2000_0300, 1, 100, 0);
    wait_done;
    check(3, prog_pass);
    dma_from_slave = 1;
    job(auto_program_mode, 32'h0, 9, 110, 0);
    aq.delete();
    bq.delete();
    for (int i = 2; i < 12; i++)
    begin
      w[i] = $urandom | pat(108 + i);
      ahb(1, 16'hfffc, w[i]);
    end
    check(1, waitn > 100);
    wait_done;
    check(3, prog_pass);
    dma_from_slave = 0;
    operating_mode_field = manual_read_mode;
    for (int i = 0; i < 12; i++)
    begin
      rq.push_back(w[i]);
      ahb(0, 16'((i < 2 ? 100 + i : 108 + i) * 4), 0);
    end
    // second reset with no job running: status clears, window serves again
    arst_n = 0;
    repeat (2) @(posedge clk);
    #1 check(4'h3, {prog_pass, s_hreadyout, macro_standby});
    arst_n = 1;
    repeat (3) @(posedge clk);
    #1 rq.push_back(w[0]);
    ahb(0, 16'd400, 0);
    finish_test;
  end
endmodule
